/* File: verilog/mmu_fault_pkg.sv */
// Shared constants and types for the MMU fault reporting block
package mmu_fault_pkg;
  // Fault level codes
  localparam logic [1:0] LVL_CTX = 2'h0;
  localparam logic [1:0] LVL_L1 = 2'h1;
  localparam logic [1:0] LVL_L2 = 2'h2;
  localparam logic [1:0] LVL_L3 = 2'h3;
  // Fault kind codes
  localparam logic [2:0] FT_NONE = 3'h0;
  localparam logic [2:0] FT_INVALID = 3'h1;
  localparam logic [2:0] FT_PROT = 3'h2;
  localparam logic [2:0] FT_PRIV = 3'h3;
  localparam logic [2:0] FT_XLATE = 3'h4;
  localparam logic [2:0] FT_BUSERR = 3'h5;
  localparam logic [2:0] FT_INTERNAL = 3'h6;
  localparam logic [2:0] FT_RSVD = 3'h7;
  // Access kind bit meanings: bit2 store, bit1 instruction space, bit0 supervisor
  localparam int AK_STORE = 2;
  localparam int AK_INSTR = 1;
  // Entry kind codes
  localparam logic [1:0] ET_INVALID = 2'h0;
  localparam logic [1:0] ET_PTD = 2'h1;
  localparam logic [1:0] ET_PTE = 2'h2;
  localparam logic [1:0] ET_RSVD = 2'h3;
  // Page entry field positions
  localparam int PTE_ACC_LO = 2;
  localparam int PTE_REF = 5;
  localparam int PTE_MOD = 6;
  // Address space tags
  localparam logic [7:0] SPACE_REGS = 8'h04;
  // Register select codes on address bits 11:8
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FSR = 4'h3;
  localparam logic [3:0] REG_FAR = 4'h4;
  // Control and fault status field positions
  localparam int CTRL_E = 0;
  localparam int CTRL_PSO = 7;
  localparam int FSR_OW = 0;
  localparam int FSR_FAV = 1;
  localparam int FSR_FT_LO = 2;
  localparam int FSR_AT_LO = 5;
  localparam int FSR_L_LO = 8;
  localparam int FSR_EBE_LO = 10;
  localparam int EBE_MAX = 8;
  localparam logic [11:0] VPN_OFS_ZERO = 12'h000;
  // Protection and privilege matrices, one mask per access kind, bit = permission code
  localparam logic [7:0] PROT_MASK [8] = '{8'h10, 8'h10, 8'h23, 8'h23,
                                          8'h35, 8'h55, 8'h37, 8'h77};
  localparam logic [7:0] PRIV_MASK [8] = '{8'hc0, 8'h00, 8'hc0, 8'h00,
                                          8'hc0, 8'h00, 8'hc0, 8'h00};
  // Fault class of recorded status
  typedef enum logic [1:0] {CLS_NONE, CLS_INSTR, CLS_DATA, CLS_TABLE} fault_cls_e;
endpackage

/* File: verilog/perm_check.sv */
// Permission check of one page entry against one access kind
`timescale 1ns/1ps
module perm_check (
  input wire logic [2:0] access_kind,
  input wire logic entry_present,
  input wire logic [2:0] permission_code,
  output logic flt_invalid,
  output logic flt_priv,
  output logic flt_prot
);
  import mmu_fault_pkg::*;

  // Absent entry always gives invalid; otherwise matrix lookup
  always_comb begin
    flt_invalid = !entry_present;
    flt_priv = entry_present && PRIV_MASK[access_kind][permission_code];
    flt_prot = entry_present && PROT_MASK[access_kind][permission_code];
  end
endmodule

/* File: verilog/fault_prio.sv */
// Picks the highest priority fault out of simultaneous error flags
`timescale 1ns/1ps
module fault_prio (
  input wire logic [5:0] flags,
  output logic [2:0] fault_kind,
  output logic any_fault
);
  import mmu_fault_pkg::*;

  // Flags: 5 internal, 4 translation, 3 invalid, 2 privilege, 1 protection, 0 bus
  always_comb begin
    any_fault = |flags;
    if (flags[5]) begin
      fault_kind = FT_INTERNAL;
    end else if (flags[4]) begin
      fault_kind = FT_XLATE;
    end else if (flags[3]) begin
      fault_kind = FT_INVALID;
    end else if (flags[2]) begin
      fault_kind = FT_PRIV;
    end else if (flags[1]) begin
      fault_kind = FT_PROT;
    end else if (flags[0]) begin
      fault_kind = FT_BUSERR;
    end else begin
      fault_kind = FT_NONE;
    end
  end
endmodule

/* File: verilog/mmu_fault_reporting.sv */
// MMU fault classification, recording, table walk and referenced/modified upkeep
// Function
// - Level field: 0 context table, 1 to 3 page table levels.
// - Access kind: loads 0-3, stores 4-7, user/super data then instruction.
// - Fault kind codes 0 none through 6 internal, 7 reserved.
// - Invalid comes from an absent entry; protection, privilege from access kind and permission matrix.
// - Translation fault on walk bus error, level-3 pointer, or entry kind 3.
// - Translation fault records walk level and bus error code.
// - Bus error outside a walk gives fault kind 5 with its code.
// - Internal inconsistency gives fault kind 6.
// - Address-valid set when fault address register holds a valid address.
// - Same-class repeat write before a read sets the clobber flag.
// - Several errors on one access: record only the highest priority.
// - Reading fault status returns then clears it; writes ignored.
// - Fault address follows status priority; writes ignored.
// - Optionally latch only the page number, low bits zero.
// - Translation fault address is the original virtual address.
// - Reset clears translation enable and partial store order only.
// - Cache miss walks tables, caches the entry, then checks and translates.
// - Successful translation sets a clear referenced bit in cache and memory.
// - Successful write sets a clear modified bit in cache and memory.
// - Bit updates locked and done before the access completes.
// - Space tag is 8 bits and fully decoded.
// - Internal registers answer in space 4.
// - Instruction faults never replace data status; data over instruction clears flag.
// - Table faults are replaced only by table faults; table over others clears flag.
`timescale 1ns/1ps
module mmu_fault_reporting #(
  parameter int TC_DEPTH = 4,
  parameter bit FAR_VPN_ONLY = 1'b0,
  parameter int EBE_W = 8
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic por_b,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [7:0] reg_space,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  output logic reg_ack,
  output logic [31:0] reg_rdata,
  output logic xlate_en,
  output logic pso_mode,
  input wire logic [31:0] ctp_base,
  input wire logic [7:0] ctx_num,
  input wire logic xr_valid,
  input wire logic [2:0] xr_kind,
  input wire logic [31:0] xr_vaddr,
  output logic xr_idle,
  output logic xr_done,
  output logic xr_fault,
  output logic [31:0] xr_paddr,
  input wire logic abe_valid,
  input wire logic [2:0] abe_kind,
  input wire logic [31:0] abe_vaddr,
  input wire logic [EBE_W-1:0] abe_code,
  output logic mem_req,
  output logic mem_wr,
  output logic mem_lock,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [EBE_W-1:0] mem_err_code,
  input wire logic [31:0] mem_rdata
);
  import mmu_fault_pkg::*;

  localparam int IW = $clog2(TC_DEPTH);

  // Index slicing needs a power-of-two cache depth
  if (TC_DEPTH < 2 || (TC_DEPTH & (TC_DEPTH - 1)) != 0) begin
    $error("TC_DEPTH must be a power of two of at least 2");
  end
  // Status field has room for eight error bits only
  if (EBE_W < 1 || EBE_W > EBE_MAX) begin
    $error("EBE_W must be 1 to 8");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_WALK = 3'b011,
    ST_EVAL = 3'b010,
    ST_UPDATE = 3'b110
  } walk_state_e;

  // Table index for the fetch at a given level
  function automatic logic [31:0] tbl_offset(input logic [1:0] lvl, input logic [31:0] va);
    logic [7:0] idx;
    idx = 8'h00;
    unique case (lvl)
      LVL_L1: idx = va[31:24];
      LVL_L2: idx = {2'b00, va[23:18]};
      LVL_L3: idx = {2'b00, va[17:12]};
      LVL_CTX: idx = 8'h00;
    endcase
    tbl_offset = {22'h000000, idx, 2'b00};
  endfunction

  // Offset bits passed through untranslated for a page found at a level
  function automatic logic [31:0] page_mask(input logic [1:0] lvl);
    unique case (lvl)
      LVL_CTX: page_mask = 32'hffffffff;
      LVL_L1: page_mask = 32'h00ffffff;
      LVL_L2: page_mask = 32'h0003ffff;
      LVL_L3: page_mask = 32'h00000fff;
    endcase
  endfunction

  walk_state_e state;
  logic [2:0] req_kind;
  logic [31:0] req_va;
  logic [1:0] lvl;
  logic [31:0] work_pte;
  logic [31:0] work_addr;
  logic [1:0] work_lvl;
  logic work_present;
  // Translation cache arrays
  logic tc_valid [TC_DEPTH];
  logic [19:0] tc_tag [TC_DEPTH];
  logic [31:0] tc_pte [TC_DEPTH];
  logic [31:0] tc_addr [TC_DEPTH];
  logic [1:0] tc_lvl [TC_DEPTH];
  // Fault events raised by the walk engine
  logic [5:0] ev_flags;
  logic [2:0] ev_kind;
  logic [1:0] ev_lvl;
  logic [31:0] ev_va;
  logic [EBE_W-1:0] ev_ebe;
  logic ev_table;
  // Recorded status
  logic [EBE_W-1:0] fsr_ebe;
  logic [1:0] fsr_lvl;
  logic [2:0] fsr_at;
  logic [2:0] fsr_ft;
  logic fsr_fav;
  logic fsr_ow;
  fault_cls_e fsr_cls;
  logic [31:0] fault_addr_reg;

  logic [IW-1:0] tc_idx;
  logic tc_hit;
  logic [1:0] ent_et;
  logic p_inv;
  logic p_priv;
  logic p_prot;
  logic need_r;
  logic need_m;
  logic [31:0] upd_pte;
  logic [5:0] all_flags;
  logic [2:0] win_ft;
  logic win_any;
  logic win_abe;
  fault_cls_e new_cls;
  fault_cls_e eff_cls;
  logic fsr_rd;
  logic reg_hit;
  logic tc_fill;
  logic tc_upd;
  logic rec_write;
  logic [31:0] fault_status;

  assign tc_idx = req_va[12 +: IW];
  assign tc_hit = tc_valid[tc_idx] && (tc_tag[tc_idx] == req_va[31:12]);
  assign ent_et = mem_rdata[1:0];
  assign need_r = !work_pte[PTE_REF];
  assign need_m = req_kind[AK_STORE] && !work_pte[PTE_MOD];
  assign upd_pte = work_pte | (32'h1 << PTE_REF) | ({31'h0, need_m} << PTE_MOD);
  // Full 8-bit space compare so aliases of space 4 never hit the registers
  assign reg_hit = reg_req && (reg_space == SPACE_REGS);
  assign fsr_rd = reg_hit && !reg_wr && (reg_addr[11:8] == REG_FSR);
  assign tc_fill = (state == ST_WALK) && mem_ack && !mem_err && (ent_et == ET_PTE);
  assign tc_upd = (state == ST_EVAL) && !(p_inv || p_priv || p_prot) && (need_r || need_m);

  perm_check u_perm (
    .access_kind(req_kind),
    .entry_present(work_present),
    .permission_code(work_pte[PTE_ACC_LO +: 3]),
    .flt_invalid(p_inv),
    .flt_priv(p_priv),
    .flt_prot(p_prot)
  );

  // Walk engine events merge with same-cycle bus errors from the core
  assign all_flags = ev_flags | {5'b00000, abe_valid};

  fault_prio u_prio (
    .flags(all_flags),
    .fault_kind(win_ft),
    .any_fault(win_any)
  );

  assign win_abe = (win_ft == FT_BUSERR);

  // Class of the winning fault
  always_comb begin
    if (!win_abe && ev_table) begin
      new_cls = CLS_TABLE;
    end else if (win_abe ? abe_kind[AK_INSTR] : ev_kind[AK_INSTR]) begin
      new_cls = CLS_INSTR;
    end else begin
      new_cls = CLS_DATA;
    end
  end

  // A read in the same cycle empties the register first, so the new fault wins
  assign eff_cls = fsr_rd ? CLS_NONE : fsr_cls;
  assign rec_write = win_any && !(eff_cls == CLS_TABLE && new_cls != CLS_TABLE)
                     && !(eff_cls == CLS_DATA && new_cls == CLS_INSTR);

  assign fault_status = (32'(fsr_ebe) << FSR_EBE_LO) | (32'(fsr_lvl) << FSR_L_LO)
                        | (32'(fsr_at) << FSR_AT_LO) | (32'(fsr_ft) << FSR_FT_LO)
                        | (32'(fsr_fav) << FSR_FAV) | (32'(fsr_ow) << FSR_OW);

  // Control bits; MMU reset touches nothing else
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xlate_en <= 1'b0;
      pso_mode <= 1'b0;
    end else if (reg_hit && reg_wr && reg_addr[11:8] == REG_CTRL) begin
      xlate_en <= reg_wdata[CTRL_E];
      pso_mode <= reg_wdata[CTRL_PSO];
    end
  end

  // Register read port; every space 4 access is acknowledged, status and address writes are ignored
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_ack <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      reg_ack <= reg_hit;
      reg_rdata <= 32'h00000000;
      if (reg_hit && !reg_wr) begin
        unique case (reg_addr[11:8])
          REG_CTRL: reg_rdata <= (32'(xlate_en) << CTRL_E) | (32'(pso_mode) << CTRL_PSO);
          REG_FSR: reg_rdata <= fault_status;
          REG_FAR: reg_rdata <= fault_addr_reg;
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Fault record; survives MMU reset, cleared at power-on and, except the address, by a status read
  always_ff @(posedge mclk or negedge por_b) begin
    if (!por_b) begin
      fsr_ebe <= '0;
      fsr_lvl <= 2'h0;
      fsr_at <= 3'h0;
      fsr_ft <= FT_NONE;
      fsr_fav <= 1'b0;
      fsr_ow <= 1'b0;
      fsr_cls <= CLS_NONE;
      fault_addr_reg <= 32'h00000000;
    end else if (rec_write) begin
      fsr_ft <= win_ft;
      fsr_at <= win_abe ? abe_kind : ev_kind;
      fsr_lvl <= win_abe ? LVL_CTX : ev_lvl;
      fsr_ebe <= win_abe ? abe_code : ev_ebe;
      fsr_fav <= 1'b1;
      fsr_ow <= (eff_cls == new_cls);
      fsr_cls <= new_cls;
      // Original virtual address, never the table entry address
      fault_addr_reg <= win_abe ? abe_vaddr : ev_va;
      if (FAR_VPN_ONLY) begin
        fault_addr_reg[11:0] <= VPN_OFS_ZERO;
      end
    end else if (fsr_rd) begin
      fsr_ft <= FT_NONE;
      fsr_ow <= 1'b0;
      fsr_fav <= 1'b0;
      fsr_ebe <= '0;
      fsr_lvl <= 2'h0;
      fsr_at <= 3'h0;
      fsr_cls <= CLS_NONE;
    end
  end

  // Translation cache fill on a walk and referenced/modified refresh
  always_ff @(posedge mclk or negedge por_b) begin
    if (!por_b) begin
      for (int i = 0; i < TC_DEPTH; i++) begin
        tc_valid[i] <= 1'b0;
      end
    end else if (tc_fill) begin
      tc_valid[tc_idx] <= 1'b1;
      tc_tag[tc_idx] <= req_va[31:12];
      tc_pte[tc_idx] <= mem_rdata;
      tc_addr[tc_idx] <= mem_addr;
      tc_lvl[tc_idx] <= lvl;
    end else if (tc_upd) begin
      tc_pte[tc_idx] <= upd_pte;
    end
  end

  // Walk engine: lookup, table walk, permission check, bit update
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      xr_idle <= 1'b1;
      xr_done <= 1'b0;
      xr_fault <= 1'b0;
      xr_paddr <= 32'h00000000;
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_lock <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      req_kind <= 3'h0;
      req_va <= 32'h00000000;
      lvl <= LVL_CTX;
      work_pte <= 32'h00000000;
      work_addr <= 32'h00000000;
      work_lvl <= LVL_CTX;
      work_present <= 1'b0;
      ev_flags <= 6'h00;
      ev_kind <= 3'h0;
      ev_lvl <= LVL_CTX;
      ev_va <= 32'h00000000;
      ev_ebe <= '0;
      ev_table <= 1'b0;
    end else begin
      xr_done <= 1'b0;
      xr_fault <= 1'b0;
      ev_flags <= 6'h00;
      ev_table <= 1'b0;
      ev_ebe <= '0;
      unique case (state)
        ST_IDLE: begin
          if (xr_valid) begin
            req_kind <= xr_kind;
            req_va <= xr_vaddr;
            if (xlate_en) begin
              state <= ST_CHECK;
              xr_idle <= 1'b0;
            end else begin
              // Disabled: address passes straight through
              xr_done <= 1'b1;
              xr_paddr <= xr_vaddr;
            end
          end
        end
        ST_CHECK: begin
          mem_lock <= 1'b1;
          if (tc_hit) begin
            work_pte <= tc_pte[tc_idx];
            work_addr <= tc_addr[tc_idx];
            work_lvl <= tc_lvl[tc_idx];
            work_present <= 1'b1;
            state <= ST_EVAL;
          end else begin
            lvl <= LVL_CTX;
            mem_addr <= ctp_base + {22'h000000, ctx_num, 2'b00};
            mem_req <= 1'b1;
            state <= ST_WALK;
          end
        end
        ST_WALK: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            ev_kind <= req_kind;
            ev_va <= req_va;
            ev_lvl <= lvl;
            if (mem_err) begin
              ev_flags <= 6'h10;
              ev_ebe <= mem_err_code;
              ev_table <= 1'b1;
              mem_lock <= 1'b0;
              xr_done <= 1'b1;
              xr_fault <= 1'b1;
              xr_idle <= 1'b1;
              state <= ST_IDLE;
            end else if ((ent_et == ET_PTD && lvl == LVL_L3) || ent_et == ET_RSVD) begin
              ev_flags <= 6'h10;
              mem_lock <= 1'b0;
              xr_done <= 1'b1;
              xr_fault <= 1'b1;
              xr_idle <= 1'b1;
              state <= ST_IDLE;
            end else if (ent_et == ET_PTD) begin
              lvl <= lvl + 2'h1;
              mem_addr <= {mem_rdata[31:2], 2'b00} + tbl_offset(lvl + 2'h1, req_va);
              mem_req <= 1'b1;
            end else begin
              // Page entry cached on the way, or absent entry checked as invalid
              work_pte <= mem_rdata;
              work_addr <= mem_addr;
              work_lvl <= lvl;
              work_present <= (ent_et == ET_PTE);
              state <= ST_EVAL;
            end
          end
        end
        ST_EVAL: begin
          ev_kind <= req_kind;
          ev_va <= req_va;
          ev_lvl <= work_lvl;
          xr_paddr <= ({work_pte[27:8], 12'h000} & ~page_mask(work_lvl))
                      | (req_va & page_mask(work_lvl));
          if (p_inv || p_priv || p_prot) begin
            ev_flags <= {2'b00, p_inv, p_priv, p_prot, 1'b0};
            mem_lock <= 1'b0;
            xr_done <= 1'b1;
            xr_fault <= 1'b1;
            xr_idle <= 1'b1;
            state <= ST_IDLE;
          end else if (need_r || need_m) begin
            // Memory copy written under lock before the access may complete
            mem_addr <= work_addr;
            mem_wdata <= upd_pte;
            mem_wr <= 1'b1;
            mem_req <= 1'b1;
            state <= ST_UPDATE;
          end else begin
            mem_lock <= 1'b0;
            xr_done <= 1'b1;
            xr_idle <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_UPDATE: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_wr <= 1'b0;
            mem_lock <= 1'b0;
            xr_done <= 1'b1;
            xr_fault <= mem_err;
            xr_idle <= 1'b1;
            ev_flags <= {1'b0, mem_err, 4'h0};
            ev_ebe <= mem_err_code;
            ev_table <= mem_err;
            state <= ST_IDLE;
          end
        end
        default: begin
          // Corrupted state code: report and recover
          ev_flags <= 6'h20;
          ev_kind <= req_kind;
          ev_va <= req_va;
          mem_req <= 1'b0;
          mem_wr <= 1'b0;
          mem_lock <= 1'b0;
          xr_done <= 1'b1;
          xr_fault <= 1'b1;
          xr_idle <= 1'b1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  fsr_read_clr_a: assert property (@(posedge mclk) disable iff (!por_b)
    fsr_rd && !win_any |=> fsr_ft == FT_NONE && !fsr_ow) else $error("status not cleared");
  far_wr_ign_a: assert property (@(posedge mclk) disable iff (!por_b)
    reg_hit && reg_wr && !win_any |=> $stable(fault_addr_reg)) else $error("address write took");
  ctrl_reset_a: assert property (@(posedge mclk)
    $rose(rst_b) |-> !xlate_en && !pso_mode) else $error("control not reset");
  ptd_l3_xlate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    state == ST_WALK && mem_ack && !mem_err && ent_et == ET_PTD && lvl == LVL_L3
    |=> ev_flags[4] && xr_fault) else $error("level-3 pointer not flagged");
  mod_set_mem_a: assert property (@(posedge mclk) disable iff (!rst_b)
    tc_upd && req_kind[AK_STORE] |=> mem_wr && mem_wdata[PTE_MOD] && mem_wdata[PTE_REF])
    else $error("modified bit not written");
  done_after_upd_a: assert property (@(posedge mclk) disable iff (!rst_b)
    mem_req && mem_wr |-> !xr_done && mem_lock) else $error("completed before update");
  instr_keep_data_a: assert property (@(posedge mclk) disable iff (!por_b)
    fsr_cls == CLS_DATA && !fsr_rd && win_any && new_cls == CLS_INSTR
    |=> $stable(fsr_ft) && $stable(fault_addr_reg)) else $error("data status replaced");
  table_keep_a: assert property (@(posedge mclk) disable iff (!por_b)
    fsr_cls == CLS_TABLE && !fsr_rd && win_any && new_cls != CLS_TABLE
    |=> fsr_cls == CLS_TABLE && $stable(fault_addr_reg)) else $error("table status replaced");
  same_cls_ow_a: assert property (@(posedge mclk) disable iff (!por_b)
    rec_write && fsr_cls == new_cls && !fsr_rd |=> fsr_ow && fsr_fav)
    else $error("clobber flag not set");
endmodule

/* File: test/pt_mem_model.sv */
// Page table memory model facing the table walk engine
`timescale 1ns/1ps
module pt_mem_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic mem_err,
  output logic [7:0] mem_err_code,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [16];
  logic [31:0] last;
  // Word 14 answers with a bus fault so walk errors get exercised
  assign mem_err = mem_ack && (mem_addr[5:2] == 4'he);
  assign mem_err_code = mem_err ? 8'h3c : 8'h00;
  // Released bus shows the inverse of the last word, never a stale copy
  assign mem_rdata = mem_ack ? mem[mem_addr[5:2]] : ~last;
  // One-cycle answer; plain always so the bench may preload table words
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
    end else begin
      mem_ack <= mem_req && !mem_ack;
      if (mem_req && mem_ack && mem_wr) begin
        mem[mem_addr[5:2]] <= mem_wdata;
      end
      if (mem_ack) begin
        last <= mem_rdata;
      end
    end
  end
endmodule

/* File: test/mmu_fault_reporting_tb.sv */
// Self-checking bench for the MMU fault reporting block
`timescale 1ns/1ps
module mmu_fault_reporting_tb;
  import mmu_fault_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic por_b = 1'b0;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_space = 8'h00;
  logic [31:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic xr_valid = 1'b0;
  logic [2:0] xr_kind = '0;
  logic [31:0] xr_vaddr = '0;
  logic abe_valid = 1'b0;
  logic [2:0] abe_kind = '0;
  logic [31:0] abe_vaddr = '0;
  logic [7:0] abe_code = '0;
  logic reg_ack, xlate_en, pso_mode, xr_idle, xr_done, xr_fault;
  logic mem_req, mem_wr, mem_lock, mem_ack, mem_err;
  logic [7:0] mem_err_code;
  logic [31:0] reg_rdata, xr_paddr, mem_addr, mem_wdata, mem_rdata;
  logic f;
  logic a;
  logic [31:0] q;
  int err_count = 0;
  int n_compared = 0;
  always #50 mclk = ~mclk;
  mmu_fault_reporting mmu_fault_reporting_i (.mclk(mclk), .rst_b(rst_b), .por_b(por_b),
    .reg_req(reg_req), .reg_wr(reg_wr), .reg_space(reg_space), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata), .xlate_en(xlate_en),
    .pso_mode(pso_mode), .ctp_base(32'h0), .ctx_num(8'h00), .xr_valid(xr_valid),
    .xr_kind(xr_kind), .xr_vaddr(xr_vaddr), .xr_idle(xr_idle), .xr_done(xr_done),
    .xr_fault(xr_fault), .xr_paddr(xr_paddr), .abe_valid(abe_valid), .abe_kind(abe_kind),
    .abe_vaddr(abe_vaddr), .abe_code(abe_code), .mem_req(mem_req), .mem_wr(mem_wr),
    .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_err_code(mem_err_code), .mem_rdata(mem_rdata));
  pt_mem_model pt_mem_model_i (.mclk(mclk), .rst_b(rst_b), .mem_req(mem_req),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_err_code(mem_err_code), .mem_rdata(mem_rdata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // One register access; answer is sampled the cycle after the request
  task automatic acc(input logic w, input logic [7:0] sp, input logic [31:0] ad,
                     input logic [31:0] d);
    @(negedge mclk);
    reg_req = 1'b1;
    reg_wr = w;
    reg_space = sp;
    reg_addr = ad;
    reg_wdata = d;
    @(negedge mclk);
    a = reg_ack;
    q = reg_rdata;
    reg_req = 1'b0;
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] exp, input string what);
    acc(1'b0, SPACE_REGS, ad, '0);
    chk({what, " ack"}, 32'h1, {31'h0, a});
    chk(what, exp, q);
  endtask
  task automatic bus_err(input logic [2:0] k, input logic [31:0] va, input logic [7:0] c);
    @(negedge mclk);
    abe_valid = 1'b1;
    abe_kind = k;
    abe_vaddr = va;
    abe_code = c;
    @(negedge mclk);
    abe_valid = 1'b0;
  endtask
  // Bounded wait for completion; a hang shows as a missing done
  task automatic xlate(input logic [2:0] k, input logic [31:0] va);
    int n;
    @(negedge mclk);
    xr_valid = 1'b1;
    xr_kind = k;
    xr_vaddr = va;
    @(negedge mclk);
    xr_valid = 1'b0;
    n = 0;
    while (xr_done !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk("xr_done", 32'h1, {31'h0, xr_done});
    chk("xr_idle", 32'h1, {31'h0, xr_idle});
    chk("mem_lock", 32'h0, {31'h0, mem_lock});
    f = xr_fault;
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    err_count++;
    $display("unexpected run length: expected finish, seen timeout");
    summarize();
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    por_b = 1'b1;
    chk("xlate_en", 32'h0, {31'h0, xlate_en});
    xlate(3'h0, 32'habcd_e123);
    chk("bypass paddr", 32'habcd_e123, xr_paddr);
    acc(1'b1, SPACE_REGS, 32'h000, 32'h81);
    chk("write ack", 32'h1, {31'h0, a});
    chk("pso_mode", 32'h1, {31'h0, pso_mode});
    $display("test control done");
    bus_err(3'h5, 32'h1234_5678, 8'h5a);
    acc(1'b1, SPACE_REGS, 32'h300, 32'hffff_ffff);
    acc(1'b1, SPACE_REGS, 32'h400, 32'h0);
    @(negedge mclk);
    rst_b = 1'b0;
    @(negedge mclk);
    rst_b = 1'b1;
    chk("pso after reset", 32'h0, {31'h0, pso_mode});
    rd(32'h300, 32'h0001_68b6, "status");
    rd(32'h400, 32'h1234_5678, "address");
    rd(32'h300, 32'h0, "cleared status");
    $display("test bus error done");
    bus_err(3'h0, 32'h100, 8'h01);
    bus_err(3'h1, 32'h200, 8'h02);
    bus_err(3'h2, 32'h300, 8'h03);
    rd(32'h300, 32'h0000_0837, "repeat status");
    rd(32'h400, 32'h200, "repeat address");
    acc(1'b0, 8'h03, 32'h300, '0);
    chk("space 3 ack", 32'h0, {31'h0, a});
    acc(1'b0, 8'h84, 32'h300, '0);
    chk("space 84 ack", 32'h0, {31'h0, a});
    $display("test overwrite done");
    acc(1'b1, SPACE_REGS, 32'h000, 32'h01);
    pt_mem_model_i.mem[0] = 32'h11;
    pt_mem_model_i.mem[4] = 32'h101a;
    xlate(3'h0, 32'h1000);
    chk("privilege fault", 32'h1, {31'h0, f});
    rd(32'h300, 32'h10e, "privilege status");
    pt_mem_model_i.mem[4] = 32'h100e;
    xlate(3'h4, 32'h2000);
    chk("store fault", 32'h0, {31'h0, f});
    chk("updated entry", 32'h106e, pt_mem_model_i.mem[4]);
    pt_mem_model_i.mem[4] = 32'h3;
    xlate(3'h0, 32'h3000);
    rd(32'h300, 32'h112, "translation status");
    rd(32'h400, 32'h3000, "translation address");
    pt_mem_model_i.mem[4] = 32'h21;
    pt_mem_model_i.mem[8] = 32'h31;
    pt_mem_model_i.mem[15] = 32'h1;
    xlate(3'h0, 32'h3000);
    chk("level-3 pointer fault", 32'h1, {31'h0, f});
    rd(32'h300, 32'h312, "level-3 status");
    xlate(3'h0, 32'h2_2000);
    chk("walk bus error fault", 32'h1, {31'h0, f});
    bus_err(3'h0, 32'h500, 8'h11);
    rd(32'h300, 32'h0000_f312, "table status");
    rd(32'h400, 32'h2_2000, "table address");
    xlate(3'h0, 32'h2000);
    chk("cached hit fault", 32'h0, {31'h0, f});
    $display("test walk done");
    summarize();
  end
endmodule
